/* File: logic/ddsc_map.svh */
// Offsets, field widths, reset values and counts of the synthesizer control block.
// Included by the package and the top module; holds definitions only.
`ifndef DDSC_MAP_SVH
`define DDSC_MAP_SVH

// Datapath widths
`define DDSC_ACC_W 28
`define DDSC_PH_W 12
`define DDSC_HALF_W 14
`define DDSC_CTRL_W 7

// APB byte offsets, one aligned word each
`define DDSC_ADDR_W 8
`define DDSC_OFF_CTRL 8'h00
`define DDSC_OFF_TUNE_A 8'h04
`define DDSC_OFF_TUNE_B 8'h08
`define DDSC_OFF_PHASE_A 8'h0C
`define DDSC_OFF_PHASE_B 8'h10
`define DDSC_OFF_STATUS 8'h14
`define DDSC_OFF_ACC 8'h18

// Reset values
`define DDSC_CTRL_RST 7'h00
`define DDSC_TUNE_RST 28'h000_0000
`define DDSC_PH_RST 12'h000
`define DDSC_ACC_RST 28'h000_0000

// Serial word framing
`define DDSC_SER_W 16
`define DDSC_CNT_RST 5'h00
`define DDSC_CNT_LAST 5'h0F
`define DDSC_CNT_DONE 5'h10
`define DDSC_TAG_CTRL 2'h0
`define DDSC_TAG_TUNE_A 2'h1
`define DDSC_TAG_TUNE_B 2'h2
`define DDSC_TAG_PHASE 2'h3
`define DDSC_SER_TAG_HI 15
`define DDSC_SER_TAG_LO 14
`define DDSC_SER_PHSEL 13

`endif

/* File: logic/ddsc_pkg.sv */
// Types of the synthesizer control block.
// Assumes the constants header sits beside it on the include path.
`include "ddsc_map.svh"

package ddsc_pkg;

    // Control word, bit 6 down to bit 0
    typedef struct packed {
        logic freq_half;
        logic logic_out_source;
        logic logic_out_enable;
        logic converter_powerdown_bit;
        logic sel_by_bits;
        logic phase_choice_bit;
        logic freq_choice_bit;
    } ddsc_ctrl_t;

    // Link side shifter, cleared whenever the frame sync is high
    typedef struct packed {
        logic [4:0] cnt;
        logic [`DDSC_SER_W-1:0] shift;
    } ddsc_shift_t;

    // Link side finished word and its event toggle
    typedef struct packed {
        logic [`DDSC_SER_W-1:0] word;
        logic tog;
    } ddsc_word_t;

    // Whole state of the master clock domain
    typedef struct packed {
        ddsc_ctrl_t ctrl;
        logic [`DDSC_ACC_W-1:0] tune_a;
        logic [`DDSC_ACC_W-1:0] tune_b;
        logic [`DDSC_PH_W-1:0] ph_a;
        logic [`DDSC_PH_W-1:0] ph_b;
        logic [`DDSC_ACC_W-1:0] acc;
        logic [`DDSC_PH_W-1:0] phase_out;
        logic [2:0] tog_s;
        logic [1:0] fpin_s;
        logic [1:0] ppin_s;
        logic [1:0] rst_s;
        logic [1:0] sleep_s;
        logic [1:0] cmp_s;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic logic_out;
        logic logic_out_oe_n;
        logic dac_sleep;
    } ddsc_core_t;

endpackage

/* File: logic/ddsc_top.sv */
// Control front end of a direct digital synthesizer: serial word port, APB
// register file, phase accumulator with offset adder, pin and bit selection.
// Assumes pclk is the master clock and sclk the host's serial clock, unrelated.
//
// Notes on behaviour
// - Output frequency is the selected tuning word times master clock over 2^28.
// - Frequency select chooses which tuning word feeds the accumulator increment.
// - Frequency choice comes from the pin or a control bit; host steadies pin.
// - Phase select chooses which offset register is added to accumulator output.
// - Phase choice comes from the pin or a control bit; host steadies pin.
// - Active-high reset input clears the accumulator, output sits at midscale.
// - That reset input leaves tuning, phase and control registers untouched.
// - Sleep input high powers down the converter.
// - Sleep input and power-down bit act alike; either puts converter asleep.
// - Each serial transfer carries one sixteen-bit word.
// - One data bit sampled on each falling serial clock edge.
// - Frame sync going low starts a fresh word.
// - Logic output driven only while its enable bit is 1.
// - A control bit picks comparator result or accumulator MSB for logic output.
// - Accumulator is 28 bits, adds selected word every master clock, wraps.
// - Selected 12-bit offset is added to the accumulator's upper bits.
// - Phase passed to the sine lookup is the top 12 bits only.
// - Changing frequency register never disturbs the accumulator value.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ddsc_map.svh"

module ddsc_top
    import ddsc_pkg::*;
#(
    parameter int ACC_W = `DDSC_ACC_W,
    parameter int PH_W = `DDSC_PH_W
) (
    // APB slave, master clock domain
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DDSC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial word port, serial clock domain
    input wire logic sclk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    // Asynchronous control pins
    input wire logic freq_choice_pin,
    input wire logic phase_choice_pin,
    input wire logic dds_reset,
    input wire logic sleep_pin,
    input wire logic comparator_in,
    // Datapath and pin outputs
    output logic [`DDSC_PH_W-1:0] phase_out,
    output logic dac_sleep,
    output logic logic_out,
    output logic logic_out_oe_n
);

    // Struct layout is fixed in the package
    if (ACC_W != `DDSC_ACC_W || PH_W != `DDSC_PH_W) begin : g_bad_width
        $error("ddsc_top: widths must match the package types");
    end

    // Word counter and tag positions assume a sixteen-bit serial word
    if (`DDSC_CNT_DONE != `DDSC_SER_W) begin : g_bad_count
        $error("ddsc_top: word count must equal the serial word width");
    end

    // Tuning words are loaded serially as two equal halves
    if (2 * `DDSC_HALF_W != `DDSC_ACC_W) begin : g_bad_half
        $error("ddsc_top: two halves must fill a tuning word");
    end

    ddsc_shift_t sh_q;
    ddsc_shift_t sh_d;
    ddsc_word_t lw_q;
    ddsc_word_t lw_d;
    ddsc_core_t q;
    ddsc_core_t d;

    // Replace one 14-bit half of a tuning word
    function automatic logic [`DDSC_ACC_W-1:0] put_half(
        input logic [`DDSC_ACC_W-1:0] old,
        input logic upper,
        input logic [`DDSC_HALF_W-1:0] half
    );
        logic [`DDSC_ACC_W-1:0] res;
        res = old;
        if (upper) begin
            res[`DDSC_ACC_W-1:`DDSC_HALF_W] = half;
        end else begin
            res[`DDSC_HALF_W-1:0] = half;
        end
        return res;
    endfunction

    // Offsets that answer without an error
    function automatic logic is_mapped(input logic [`DDSC_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        unique case (a)
            `DDSC_OFF_CTRL,
            `DDSC_OFF_TUNE_A,
            `DDSC_OFF_TUNE_B,
            `DDSC_OFF_PHASE_A,
            `DDSC_OFF_PHASE_B,
            `DDSC_OFF_STATUS,
            `DDSC_OFF_ACC: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // Link side: shifter takes one bit per falling edge until sixteen are in
    always_comb begin
        sh_d = sh_q;
        if (sh_q.cnt != `DDSC_CNT_DONE) begin
            // Extra edges after sixteen are ignored until the frame closes
            sh_d.shift = {sh_q.shift[`DDSC_SER_W-2:0], serial_in};
            sh_d.cnt = sh_q.cnt + 5'h01;
        end
    end

    // Link side: finished word and the toggle that tells the master domain
    always_comb begin
        lw_d = lw_q;
        if (sh_q.cnt == `DDSC_CNT_LAST) begin
            lw_d.word = {sh_q.shift[`DDSC_SER_W-2:0], serial_in};
            lw_d.tog = ~lw_q.tog;
        end
    end

    // Frame sync high clears the count, so a short frame is dropped
    always_ff @(negedge sclk or posedge frame_sync_n or negedge presetn) begin
        if (!presetn || frame_sync_n) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    // Word holds until the next full word; host spaces words by a few pclk
    always_ff @(negedge sclk or negedge presetn) begin
        if (!presetn) begin
            lw_q <= '0;
        end else begin
            lw_q <= lw_d;
        end
    end

    // Two-flop synchroniser step for a level from another domain
    function automatic logic [1:0] sync_step(input logic [1:0] s, input logic pin);
        return {s[0], pin};
    endfunction

    // Register read data; narrower registers sit in the low bits
    function automatic logic [31:0] read_word(
        input ddsc_core_t c,
        input logic [`DDSC_ADDR_W-1:0] a,
        input logic freq_pick,
        input logic phase_pick
    );
        logic [31:0] w;
        w = '0;
        unique case (a)
            `DDSC_OFF_CTRL: begin
                w = {25'h000_0000, c.ctrl};
            end
            `DDSC_OFF_TUNE_A: begin
                w = {4'h0, c.tune_a};
            end
            `DDSC_OFF_TUNE_B: begin
                w = {4'h0, c.tune_b};
            end
            `DDSC_OFF_PHASE_A: begin
                w = {20'h0_0000, c.ph_a};
            end
            `DDSC_OFF_PHASE_B: begin
                w = {20'h0_0000, c.ph_b};
            end
            `DDSC_OFF_STATUS: begin
                w = {26'h000_0000,
                     c.rst_s[1],
                     c.dac_sleep,
                     phase_pick,
                     freq_pick,
                     c.logic_out,
                     c.acc[`DDSC_ACC_W-1]};
            end
            `DDSC_OFF_ACC: begin
                w = {4'h0, c.acc};
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // Bus write; read-only and unmapped offsets leave every register alone
    function automatic ddsc_core_t bus_write(
        input ddsc_core_t c,
        input logic [`DDSC_ADDR_W-1:0] a,
        input logic [31:0] wd
    );
        ddsc_core_t r;
        r = c;
        unique case (a)
            `DDSC_OFF_CTRL: begin
                r.ctrl = wd[`DDSC_CTRL_W-1:0];
            end
            `DDSC_OFF_TUNE_A: begin
                r.tune_a = wd[`DDSC_ACC_W-1:0];
            end
            `DDSC_OFF_TUNE_B: begin
                r.tune_b = wd[`DDSC_ACC_W-1:0];
            end
            `DDSC_OFF_PHASE_A: begin
                r.ph_a = wd[`DDSC_PH_W-1:0];
            end
            `DDSC_OFF_PHASE_B: begin
                r.ph_b = wd[`DDSC_PH_W-1:0];
            end
            default: begin
                r = c;
            end
        endcase
        return r;
    endfunction

    // Serial word decode by its two tag bits
    function automatic ddsc_core_t word_write(
        input ddsc_core_t c,
        input logic [`DDSC_SER_W-1:0] w
    );
        ddsc_core_t r;
        r = c;
        unique case (w[`DDSC_SER_TAG_HI:`DDSC_SER_TAG_LO])
            `DDSC_TAG_CTRL: begin
                r.ctrl = w[`DDSC_CTRL_W-1:0];
            end
            `DDSC_TAG_TUNE_A: begin
                r.tune_a = put_half(c.tune_a, c.ctrl.freq_half, w[`DDSC_HALF_W-1:0]);
            end
            `DDSC_TAG_TUNE_B: begin
                r.tune_b = put_half(c.tune_b, c.ctrl.freq_half, w[`DDSC_HALF_W-1:0]);
            end
            `DDSC_TAG_PHASE: begin
                if (w[`DDSC_SER_PHSEL]) begin
                    r.ph_b = w[`DDSC_PH_W-1:0];
                end else begin
                    r.ph_a = w[`DDSC_PH_W-1:0];
                end
            end
        endcase
        return r;
    endfunction

    // Master clock domain
    always_comb begin
        logic freq_sel;
        logic phase_sel;
        logic word_evt;
        logic [`DDSC_ACC_W-1:0] step;
        logic [`DDSC_PH_W-1:0] offs;
        freq_sel = 1'b0;
        phase_sel = 1'b0;
        word_evt = 1'b0;
        step = '0;
        offs = '0;
        d = q;

        // Only the toggle is synchronised; host spacing keeps the word still meanwhile
        d.tog_s = {q.tog_s[1:0], lw_q.tog};
        d.fpin_s = sync_step(q.fpin_s, freq_choice_pin);
        d.ppin_s = sync_step(q.ppin_s, phase_choice_pin);
        d.rst_s = sync_step(q.rst_s, dds_reset);
        d.sleep_s = sync_step(q.sleep_s, sleep_pin);
        d.cmp_s = sync_step(q.cmp_s, comparator_in);
        word_evt = q.tog_s[2] ^ q.tog_s[1];

        // Pins are ignored while the control bits rule
        if (q.ctrl.sel_by_bits) begin
            freq_sel = q.ctrl.freq_choice_bit;
            phase_sel = q.ctrl.phase_choice_bit;
        end else begin
            freq_sel = q.fpin_s[1];
            phase_sel = q.ppin_s[1];
        end
        if (freq_sel) begin
            step = q.tune_b;
        end else begin
            step = q.tune_a;
        end
        if (phase_sel) begin
            offs = q.ph_b;
        end else begin
            offs = q.ph_a;
        end

        // Reset pin touches only the datapath state
        if (q.rst_s[1]) begin
            d.acc = `DDSC_ACC_RST;
            d.phase_out = `DDSC_PH_RST;
        end else begin
            // Accumulator never reloads on a switch, phase stays continuous
            d.acc = q.acc + step;
            d.phase_out = q.acc[`DDSC_ACC_W-1 -: `DDSC_PH_W] + offs;
        end

        // Either the pin or the bit sends the converter to sleep
        if (q.sleep_s[1] || q.ctrl.converter_powerdown_bit) begin
            d.dac_sleep = 1'b1;
        end else begin
            d.dac_sleep = 1'b0;
        end
        if (q.ctrl.logic_out_source) begin
            d.logic_out = q.cmp_s[1];
        end else begin
            d.logic_out = q.acc[`DDSC_ACC_W-1];
        end
        d.logic_out_oe_n = ~q.ctrl.logic_out_enable;

        // Answer prepared in the setup cycle, so there are never wait states
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.pready = 1'b1;
            d.prdata = read_word(q, paddr, freq_sel, phase_sel);
            d.pslverr = ~is_mapped(paddr);
        end
        if (psel && penable && pwrite && q.pready) begin
            d = bus_write(d, paddr, pwdata);
        end

        // Serial word lands after the bus write, so it wins a same-cycle clash
        if (word_evt) begin
            d = word_write(d, lw_q.word);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{
                ctrl: `DDSC_CTRL_RST,
                tune_a: `DDSC_TUNE_RST,
                tune_b: `DDSC_TUNE_RST,
                ph_a: `DDSC_PH_RST,
                ph_b: `DDSC_PH_RST,
                acc: `DDSC_ACC_RST,
                phase_out: `DDSC_PH_RST,
                logic_out_oe_n: 1'b1,
                default: '0
            };
        end else begin
            q <= d;
        end
    end

    // Every output comes straight from the state flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign phase_out = q.phase_out;
    assign dac_sleep = q.dac_sleep;
    assign logic_out = q.logic_out;
    assign logic_out_oe_n = q.logic_out_oe_n;

endmodule

/* File: testbench/ddsc_host_model.sv */
// Host side of the serial port: frames one word, MSB first.
// Assumes nothing else drives the three serial lines.
`timescale 1ns/1ns
module ddsc_host_model (
    // Serial port
    output logic sclk,
    output logic frame_sync_n,
    output logic serial_in
);
    // Clock idles high between frames
    initial begin
        sclk = 1'b1;
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
    end
    // A short n cuts the frame early on purpose
    task automatic send(input logic [15:0] w, input int n);
        #7 frame_sync_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_in = w[i];
            #32 sclk = 1'b0;
            #32 sclk = 1'b1;
        end
        #32 frame_sync_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule

/* File: testbench/ddsc_top_sva.sv */
// Port assertions of the synthesizer control block, pclk domain.
// Assumes it is bound into ddsc_top.
`timescale 1ns/1ns
module ddsc_top_sva (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic dds_reset,
    input wire logic sleep_pin,
    input wire logic [11:0] phase_out,
    input wire logic dac_sleep,
    input wire logic logic_out_oe_n
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ctrl_s;
        psel && penable && pready && pwrite && paddr == 8'h0;
    endsequence
    answer_next_a: assert property (setup_s |=> pready)
        else $error("no pready");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready long");
    unmapped_err_a: assert property (setup_s ##0 paddr > 8'h18 |=> pslverr)
        else $error("no pslverr");
    reset_phase_a: assert property (dds_reset [*6] |-> phase_out == 12'h0)
        else $error("phase kept");
    sleep_pin_a: assert property (sleep_pin [*5] |-> dac_sleep)
        else $error("pin sleep");
    sleep_bit_a: assert property (ctrl_s ##0 pwdata[3] |-> ##[1:3] dac_sleep)
        else $error("bit sleep");
    out_on_a: assert property (ctrl_s ##0 pwdata[4] |-> ##[1:3] !logic_out_oe_n)
        else $error("out off");
    out_off_a: assert property (ctrl_s ##0 !pwdata[4] |-> ##[1:3] logic_out_oe_n)
        else $error("out on");
endmodule
bind ddsc_top ddsc_top_sva ddsc_top_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .dds_reset, .sleep_pin, .phase_out, .dac_sleep,
    .logic_out_oe_n);

/* File: testbench/ddsc_top_tb.sv */
// Self-checking bench of the synthesizer control block.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ns
module ddsc_top_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } ddsc_row_t;
    // Bits above each field read back 0
    ddsc_row_t rows [6] = '{
        '{8'h04, 32'hFFFF_FFFF, 32'hFFF_FFFF, 1'b0},
        '{8'h08, 32'h1234_5678, 32'h234_5678, 1'b0},
        '{8'h0C, 32'hFFFF_F123, 32'h123, 1'b0},
        '{8'h10, 32'h456, 32'h456, 1'b0},
        '{8'h00, 32'hFFFF_FF84, 32'h4, 1'b0},
        '{8'h1C, 32'hFFFF_FFFF, 32'h0, 1'b1}
    };
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic freq_choice_pin = 1'b0, phase_choice_pin = 1'b0, dds_reset = 1'b0;
    logic sleep_pin = 1'b0, comparator_in = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [11:0] phase_out;
    logic pready, pslverr, err, sclk, frame_sync_n, serial_in;
    logic dac_sleep, logic_out, logic_out_oe_n;
    int errors = 0, total_checks = 0;
    always #50 pclk = ~pclk;
    ddsc_top ddsc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sclk, .frame_sync_n, .serial_in, .freq_choice_pin,
        .phase_choice_pin, .dds_reset, .sleep_pin, .comparator_in, .phase_out,
        .dac_sleep, .logic_out, .logic_out_oe_n);
    ddsc_host_model ddsc_host_model_inst (.sclk, .frame_sync_n, .serial_in);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Entered just after a rising edge; one idle cycle follows
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t apb hang", $time);
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ser(input logic [15:0] w, input int n, input logic [7:0] a,
        input logic [31:0] q);
        ddsc_host_model_inst.send(w, n);
        repeat (6) @(posedge pclk);
        apb(1'b0, a, 32'h0);
        chk(rd, q);
    endtask
    task automatic step(input logic [11:0] q);
        logic [11:0] p, d;
        repeat (5) @(posedge pclk);
        p = phase_out;
        @(posedge pclk);
        d = phase_out - p;
        chk(32'(d), 32'(q));
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(logic_out_oe_n), 32'h1);
        chk(32'(phase_out), 32'h0);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].q);
            chk(32'(err), 32'(rows[i].e));
        end
        $display("test registers done");
        ser(16'h4ABC, 16, 8'h04, 32'hFFF_CABC);
        ser(16'h7FFF, 8, 8'h04, 32'hFFF_CABC);
        ser(16'h8000, 16, 8'h08, 32'h234_4000);
        $display("test serial done");
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        dds_reset <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'(phase_out), 32'h0);
        dds_reset <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'(phase_out), 32'h123);
        apb(1'b1, 8'h00, 32'h0);
        phase_choice_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'(phase_out), 32'h456);
        apb(1'b1, 8'h04, 32'h1_0000);
        apb(1'b1, 8'h08, 32'h3_0000);
        apb(1'b1, 8'h00, 32'h4);
        step(12'h1);
        apb(1'b1, 8'h00, 32'h5);
        step(12'h3);
        apb(1'b1, 8'h00, 32'h0);
        freq_choice_pin <= 1'b1;
        step(12'h3);
        $display("test select done");
        sleep_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'(dac_sleep), 32'h1);
        sleep_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(32'(dac_sleep), 32'h0);
        apb(1'b1, 8'h00, 32'h38);
        comparator_in <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'(dac_sleep), 32'h1);
        chk(32'({logic_out_oe_n, logic_out}), 32'h1);
        comparator_in <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(32'(logic_out), 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        repeat (3) @(posedge pclk);
        chk(32'(logic_out_oe_n), 32'h1);
        ser(16'hE789, 16, 8'h10, 32'h789);
        ser(16'h0040, 16, 8'h00, 32'h40);
        ser(16'h5555, 16, 8'h04, 32'h555_4000);
        apb(1'b1, 8'h04, 32'h800_0000);
        apb(1'b1, 8'h00, 32'h14);
        repeat (3) @(posedge pclk);
        rd = 32'(logic_out);
        @(posedge pclk);
        chk(rd ^ 32'(logic_out), 32'h1);
        chk(32'(logic_out_oe_n), 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(logic_out_oe_n), 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        $display("test pins done");
        test_done();
    end
endmodule
